// >>> verilog/trws_sequencer.v
// Reconfiguration word sequencer with AXI4-Lite registers and interrupt
//
// Functional notes
// - Mode code 000 selects analog controls mode; it is the default; here FIXED_MODE defaults to channel mode 001.
// - Mode code 001 selects channel mode; other codes are undefined.
// - Mode input used only with several modes; else the fixed mode applies.
// - Address output shows the address in use while writing words.
// - Address steps by one per word from zero to last, then wraps.
// - Address-change strobe asserted whenever the address takes a new value; here only on a step, not on address reset or leaving channel mode.
// - Strobe only after one complete 16-bit word was written.
// - Address output works only in channel reconfiguration modes.
// - Strobe and address reset are optional, channel modes only.
// - One-cycle address reset pulse returns the address to its start.
// - Done flag rises after all words, clears when a new sequence starts.
// - Reconfiguration reset in channel mode clears all sequencer registers; here the AXI4-Lite registers keep their values.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`include "trws_regs.vh"
`default_nettype none

module trws_sequencer #(
  parameter MULTI_MODE = 1,
  parameter [2:0] FIXED_MODE = `TRWS_MODE_CHANNEL,
  parameter HAS_ADDR_EN = 1,
  parameter HAS_ADDR_RESET = 1,
  parameter ADDR_BITS = 6,
  parameter WORD_BITS = `TRWS_WORD_BITS
) (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] mode_sel,
  input wire [WORD_BITS-1:0] cfg_word,
  input wire cfg_write,
  output reg cfg_ready,
  input wire addr_reset,
  input wire reconfig_reset,
  output reg [ADDR_BITS-1:0] addr_out,
  output reg addr_en,
  output reg seq_done,
  output reg chan_sdata,
  output reg chan_active,
  output reg irq,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************
  // Mode decode
  // ****************************************
  wire [2:0] eff_mode;
  wire chan_mode;
  wire seq_rst_n;
  // Without several modes the pin is ignored and the fixed mode rules
  assign eff_mode = (MULTI_MODE != 0) ? mode_sel : FIXED_MODE;
  // Analog code and undefined codes both leave the sequencer parked
  assign chan_mode = (eff_mode == `TRWS_MODE_CHANNEL);
  // Reconfiguration reset is already synchronous to aclk
  assign seq_rst_n = aresetn & ~(reconfig_reset & chan_mode);

  // ****************************************
  // Register storage
  // ****************************************
  reg [ADDR_BITS-1:0] last_addr;
  reg [1:0] int_status;
  reg [1:0] int_mask;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // ****************************************
  // Sequencer state
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WRITE = 3'b010;
  localparam [2:0] ST_STEP = 3'b100;
  reg [2:0] state;
  reg writer_start;
  reg [WORD_BITS-1:0] writer_word;
  wire writer_sdata;
  wire writer_active;
  wire writer_done;
  wire take_word;
  wire addr_clear;
  wire at_last;
  wire [ADDR_BITS-1:0] next_addr;

  assign take_word = (state == ST_IDLE) & cfg_ready & cfg_write & chan_mode;
  assign addr_clear = (HAS_ADDR_RESET != 0) & addr_reset & chan_mode;
  assign at_last = (addr_out == last_addr);
  assign next_addr = at_last ? {ADDR_BITS{1'b0}} : addr_out + 1'b1;

  // ****************************************
  // Word writer toward the channel
  // ****************************************
  trws_word_writer #(
    .WORD_BITS(WORD_BITS)
  ) u_writer (
    .aclk(aclk),
    .rst_n(seq_rst_n),
    .start(writer_start),
    .word(writer_word),
    .sdata(writer_sdata),
    .active(writer_active),
    .done(writer_done)
  );

  // ****************************************
  // Sequencer control
  // ****************************************
  // Address, strobe and done move together so the strobe marks the new value
  always @(posedge aclk) begin
    if (!seq_rst_n) begin
      state <= ST_IDLE;
      cfg_ready <= 1'b0;
      writer_start <= 1'b0;
      writer_word <= {WORD_BITS{1'b0}};
      addr_out <= {ADDR_BITS{1'b0}};
      addr_en <= 1'b0;
      seq_done <= 1'b0;
    end else begin
      writer_start <= 1'b0;
      addr_en <= 1'b0;
      case (state)
        ST_IDLE: begin
          cfg_ready <= chan_mode & ~take_word;
          if (take_word) begin
            writer_word <= cfg_word;
            writer_start <= 1'b1;
            cfg_ready <= 1'b0;
            state <= ST_WRITE;
            // First word of a fresh pass drops the old completion
            if (addr_out == {ADDR_BITS{1'b0}}) begin
              seq_done <= 1'b0;
            end
          end
        end
        ST_WRITE: begin
          cfg_ready <= 1'b0;
          if (writer_done) begin
            state <= ST_STEP;
          end
        end
        ST_STEP: begin
          cfg_ready <= 1'b0;
          state <= ST_IDLE;
          if (!addr_clear && chan_mode) begin
            addr_out <= next_addr;
            addr_en <= (HAS_ADDR_EN != 0);
            if (at_last) begin
              seq_done <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          cfg_ready <= 1'b0;
        end
      endcase
      // Outside channel mode the address is held at its start
      if (addr_clear || !chan_mode) begin
        addr_out <= {ADDR_BITS{1'b0}};
      end
    end
  end

  // ****************************************
  // Channel pins
  // ****************************************
  // One extra flop keeps the outputs registered at the top
  always @(posedge aclk) begin
    if (!seq_rst_n) begin
      chan_sdata <= 1'b0;
      chan_active <= 1'b0;
    end else begin
      chan_sdata <= writer_sdata;
      chan_active <= writer_active;
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  wire aw_take;
  wire w_take;
  wire do_write;
  wire wr_ctrl;
  wire wr_int_status;
  wire wr_int_mask;
  wire wr_mapped;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_ctrl = do_write & (aw_addr == `TRWS_OFF_CTRL) & w_strb[0];
  assign wr_int_status = do_write & (aw_addr == `TRWS_OFF_INT_STATUS) & w_strb[0];
  assign wr_int_mask = do_write & (aw_addr == `TRWS_OFF_INT_MASK) & w_strb[0];
  assign wr_mapped = (aw_addr == `TRWS_OFF_CTRL) | (aw_addr == `TRWS_OFF_STATUS) |
                     (aw_addr == `TRWS_OFF_INT_STATUS) | (aw_addr == `TRWS_OFF_INT_MASK);

  // Address and data are latched independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TRWS_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~aw_take & ~do_write;
      s_axi_wready <= ~w_held & ~w_take & ~do_write;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `TRWS_RESP_OKAY : `TRWS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control, mask and sticky status
  // ****************************************
  reg seq_done_q;
  wire seq_done_rise;
  wire [1:0] int_events;
  assign seq_done_rise = seq_done & ~seq_done_q;
  assign int_events = {seq_done_rise, addr_en};

  // Hardware set beats a write-one-to-clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_addr <= `TRWS_CTRL_LAST_RESET;
      int_mask <= `TRWS_INT_MASK_RESET;
      int_status <= 2'b00;
      seq_done_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      seq_done_q <= seq_done;
      if (wr_ctrl) begin
        last_addr <= w_data[`TRWS_CTRL_LAST_LSB +: ADDR_BITS];
      end
      if (wr_int_mask) begin
        int_mask <= w_data[1:0];
      end
      int_status <= (int_status & ~({2{wr_int_status}} & w_data[1:0])) | int_events;
      irq <= |(int_status & int_mask);
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  reg [31:0] rd_word;
  reg rd_ok;
  // Status gathers live sequencer state for software
  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case ({s_axi_araddr[3:2], 2'b00})
      `TRWS_OFF_CTRL: rd_word[`TRWS_CTRL_LAST_LSB +: ADDR_BITS] = last_addr;
      `TRWS_OFF_STATUS: begin
        rd_word[`TRWS_STAT_BUSY_BIT] = (state != ST_IDLE);
        rd_word[`TRWS_STAT_DONE_BIT] = seq_done;
        rd_word[`TRWS_STAT_CHMODE_BIT] = chan_mode;
        rd_word[`TRWS_STAT_ADDR_LSB +: ADDR_BITS] = addr_out;
      end
      `TRWS_OFF_INT_STATUS: rd_word[1:0] = int_status;
      `TRWS_OFF_INT_MASK: rd_word[1:0] = int_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  // One read in flight; arready drops until the data is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TRWS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `TRWS_RESP_OKAY : `TRWS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // trws_sequencer

`default_nettype wire

// >>> verilog/trws_regs.vh
// Constants of the reconfiguration word sequencer: modes, offsets, fields, resets
`ifndef TRWS_REGS_VH
`define TRWS_REGS_VH

// ****************************************
// Mode select encodings
// ****************************************
`define TRWS_MODE_ANALOG 3'b000
`define TRWS_MODE_CHANNEL 3'b001

// ****************************************
// Register byte offsets
// ****************************************
`define TRWS_OFF_CTRL 4'h0
`define TRWS_OFF_STATUS 4'h4
`define TRWS_OFF_INT_STATUS 4'h8
`define TRWS_OFF_INT_MASK 4'hc

// ****************************************
// Field positions
// ****************************************
`define TRWS_CTRL_LAST_LSB 0
`define TRWS_STAT_BUSY_BIT 0
`define TRWS_STAT_DONE_BIT 1
`define TRWS_STAT_CHMODE_BIT 2
`define TRWS_STAT_ADDR_LSB 8
`define TRWS_INT_WORD_BIT 0
`define TRWS_INT_SEQ_BIT 1

// ****************************************
// Reset values and counts
// ****************************************
`define TRWS_CTRL_LAST_RESET 6'h3f
`define TRWS_INT_MASK_RESET 2'h0
`define TRWS_WORD_BITS 16
`define TRWS_RESP_OKAY 2'b00
`define TRWS_RESP_SLVERR 2'b10

`endif

// >>> verilog/trws_word_writer.v
// Shifts one configuration word out to the channel, bit by bit, then pulses done
`include "trws_regs.vh"
`default_nettype none

module trws_word_writer #(
  parameter WORD_BITS = `TRWS_WORD_BITS
) (
  input wire aclk,
  input wire rst_n,
  input wire start,
  input wire [WORD_BITS-1:0] word,
  output reg sdata,
  output reg active,
  output reg done
);

  reg [WORD_BITS-1:0] shift;
  reg [4:0] count;

  // ****************************************
  // Shift engine
  // ****************************************
  // Start is only honoured while idle; the caller holds ready low meanwhile
  always @(posedge aclk) begin
    if (!rst_n) begin
      shift <= {WORD_BITS{1'b0}};
      count <= 5'h00;
      sdata <= 1'b0;
      active <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!active) begin
        sdata <= 1'b0;
        if (start) begin
          // First bit leaves with active, so the channel never sees a stale bit
          shift <= {word[WORD_BITS-2:0], 1'b0};
          sdata <= word[WORD_BITS-1];
          count <= 5'h00;
          active <= 1'b1;
        end
      end else begin
        if ({27'h0000000, count} == WORD_BITS - 1) begin
          active <= 1'b0;
          sdata <= 1'b0;
          done <= 1'b1;
        end else begin
          // Most significant bit first
          sdata <= shift[WORD_BITS-1];
          shift <= {shift[WORD_BITS-2:0], 1'b0};
          count <= count + 5'h01;
        end
      end
    end
  end

endmodule // trws_word_writer

`default_nettype wire

// >>> testbench/trws_seq_properties.sv
// Concurrent checks on the sequencer word port
`default_nettype none
module trws_seq_properties #(
  parameter ADDR_BITS = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] mode_sel,
  input wire logic cfg_write,
  input wire logic cfg_ready,
  input wire logic addr_reset,
  input wire logic reconfig_reset,
  input wire logic [ADDR_BITS-1:0] addr_out,
  input wire logic addr_en,
  input wire logic seq_done,
  input wire logic chan_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Word port properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic chan_mode = (mode_sel == 3'b001);
  // A word is taken, then nothing disturbs it for the full shift
  sequence s_take;
    cfg_write && cfg_ready;
  endsequence
  sequence s_quiet;
    (chan_mode && !reconfig_reset && !addr_reset) throughout (##20 1'b1);
  endsequence
  a_word_time: assert property (s_take ##0 s_quiet |-> addr_en)
    else $error("strobe missing after word");
  a_strobe_single: assert property (addr_en |=> !addr_en)
    else $error("strobe longer than one cycle");
  a_strobe_moves: assert property (addr_en |-> addr_out != $past(addr_out))
    else $error("strobe without address change");
  a_addr_step: assert property (addr_en |->
    addr_out == ADDR_BITS'($past(addr_out) + 1'b1) || addr_out == '0)
    else $error("address did not step by one");
  a_strobe_idle: assert property (addr_en |-> !chan_active)
    else $error("strobe while word shifting");
  a_mode_park: assert property ((!chan_mode) [*2] |-> addr_out == '0)
    else $error("address live outside channel mode");
  a_addr_clear: assert property (addr_reset && chan_mode |=> addr_out == '0)
    else $error("address reset ignored");
  a_reset_clear: assert property (reconfig_reset && chan_mode |=>
    !addr_en && !seq_done && !cfg_ready && !chan_active && addr_out == '0)
    else $error("reconfig reset left state");
  a_done_wrap: assert property ($rose(seq_done) |-> addr_out == '0)
    else $error("done without wrap");
  a_done_clear: assert property (s_take ##0 addr_out == '0 |=> !seq_done)
    else $error("done kept at new sequence");
endmodule // trws_seq_properties
`default_nettype wire

// >>> testbench/trws_channel_model.sv
// Channel side model: collects the serial word from the sequencer
`default_nettype none
module trws_channel_model (
  input wire logic aclk,
  input wire logic sdata,
  input wire logic active,
  output logic [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bits arrive most significant first, only while active
  always @(posedge aclk) begin
    if (active) begin
      word <= {word[14:0], sdata};
    end
  end
endmodule // trws_channel_model
`default_nettype wire

// >>> testbench/trws_sequencer_tb_top.sv
// Self-checking bench for the reconfiguration word sequencer
`include "trws_regs.vh"
`default_nettype none
module trws_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic aclk, aresetn, cfg_write, addr_reset, reconfig_reset;
  logic [2:0] mode_sel;
  logic [15:0] cfg_word;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire logic cfg_ready, addr_en, seq_done, chan_sdata, chan_active, irq;
  wire logic [5:0] addr_out;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] chan_word;
  int err_count, tests_run;
  logic [1:0] rs;
  trws_sequencer dut_u (.aclk, .aresetn, .mode_sel, .cfg_word, .cfg_write, .cfg_ready,
    .addr_reset, .reconfig_reset, .addr_out, .addr_en, .seq_done, .chan_sdata,
    .chan_active, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  trws_channel_model chan_u (.aclk(aclk), .sdata(chan_sdata), .active(chan_active),
    .word(chan_word));
  // Free-running 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rs = s_axi_rresp;
    chk(s_axi_rdata, exp);
  endtask
  // Word held with the write command until the sequencer takes it
  task automatic word(input logic [15:0] w, input logic [5:0] ea);
    @(posedge aclk);
    cfg_word <= w;
    cfg_write <= 1'b1;
    do @(posedge aclk); while (cfg_ready !== 1'b1);
    cfg_write <= 1'b0;
    do @(posedge aclk); while (addr_en !== 1'b1);
    chk(addr_out, ea);
    chk(chan_word, w);
  endtask
  task automatic stop_test;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {aresetn, cfg_write, addr_reset, reconfig_reset, mode_sel, cfg_word} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(cfg_ready, 32'h0);
    mode_sel <= 3'b010;
    repeat (3) @(posedge aclk);
    chk(cfg_ready, 32'h0);
    rdc(`TRWS_OFF_CTRL, 32'h3f);
    rdc(`TRWS_OFF_INT_MASK, 32'h0);
    // Undefined mode code reads back as outside channel mode
    rdc(`TRWS_OFF_STATUS, 32'h0);
    chk(rs, `TRWS_RESP_OKAY);
    // Short sequence of three addresses so the wrap comes quickly
    wr(`TRWS_OFF_CTRL, 32'h2);
    chk(rs, `TRWS_RESP_OKAY);
    mode_sel <= 3'b001;
    rdc(`TRWS_OFF_STATUS, 32'h4);
    word(16'ha5c3, 6'h1);
    word(16'h0001, 6'h2);
    word(16'h8000, 6'h0);
    repeat (2) @(posedge aclk);
    chk(seq_done, 32'h1);
    chk(irq, 32'h0);
    rdc(`TRWS_OFF_INT_STATUS, 32'h3);
    wr(`TRWS_OFF_INT_MASK, 32'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 32'h1);
    wr(`TRWS_OFF_INT_STATUS, 32'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 32'h0);
    rdc(`TRWS_OFF_INT_STATUS, 32'h2);
    wr(`TRWS_OFF_INT_STATUS, 32'h2);
    word(16'h1234, 6'h1);
    chk(seq_done, 32'h0);
    addr_reset <= 1'b1;
    @(posedge aclk);
    addr_reset <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(addr_out, 32'h0);
    word(16'hffff, 6'h1);
    reconfig_reset <= 1'b1;
    @(posedge aclk);
    reconfig_reset <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(addr_out, 32'h0);
    rdc(`TRWS_OFF_CTRL, 32'h2);
    word(16'h00ff, 6'h1);
    mode_sel <= `TRWS_MODE_ANALOG;
    repeat (3) @(posedge aclk);
    chk(addr_out, 32'h0);
    chk(cfg_ready, 32'h0);
    stop_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    stop_test();
  end
endmodule // trws_sequencer_tb_top
bind trws_sequencer trws_seq_properties #(.ADDR_BITS(ADDR_BITS)) prop_u (.aclk, .aresetn,
  .mode_sel, .cfg_write, .cfg_ready, .addr_reset, .reconfig_reset, .addr_out, .addr_en,
  .seq_done, .chan_active);
`default_nettype wire
